// file: jtp_pattern_gen.v
/*
 * jtp_pattern_gen.v - test pattern source for a two-link serial transmitter:
 * short and long transport patterns, D21.5 and K28.5 streams, repeated lane
 * alignment control and the modified RPAT stream, ahead of the link layer.
 * Assumes the link layer drains one octet per lane per lanes_ready cycle,
 * pulses link_init at each link initialization and ilas_done when the lane
 * alignment sequence ends; all inputs but arst_n are synchronous to clock.
 */
// Behaviour
// RQ1 - sample widths eight and twelve use short pattern
// RQ2 - twelve bit, F2 S8: six lanes nibble run
// RQ3 - twelve bit, F2 S4: three lanes, both links
// RQ4 - sixteen bit width uses the long pattern
// RQ5 - long period is K times ceil((M*S+2)/K)
// RQ6 - frame zero samples equal converter index plus one
// RQ7 - converter indices restart for the second link
// RQ8 - frame one samples equal sample position plus one
// RQ9 - later frames hold two to power N-1
// RQ10 - one walking control bit in early frames
// RQ11 - control bits zero from frame M*S on
// RQ12 - both links carry the same long pattern
// RQ13 - long pattern starts after alignment, repeats forever
// RQ14 - D21.5 mode sends continuous D21.5 characters
// RQ15 - K28.5 stream, only with 8b/10b encoding
// RQ16 - repeated alignment mode, 8b/10b only, no data
// RQ17 - sync request restarts code group sync, repeat
// RQ18 - RPAT mode cycles the twelve encoder octets
// RQ19 - one selector, applied at link init, off restores
// RQ20 - pattern frame counters aligned to multiframe start
`timescale 1ns/1ps
`include "jtp_map.vh"
module jtp_pattern_gen #(
   parameter LANES = 8, // lanes per link
   parameter M = 2, // converters per link in long format
   parameter S = 1, // samples per converter per frame in long format
   parameter N = 15, // sample resolution in long format
   parameter CS = 1, // control bits per sample in long format
   parameter K = 10, // frames per multiframe
   parameter DEPTH = 32 // buffer words
) (
   input wire clock, // 100 MHz system clock
   input wire arst_n, // async reset, active low
   input wire [2:0] test_mode_sel, // test mode selector
   input wire [2:0] link_format_select, // link format code
   input wire enc_8b10b, // high when link uses 8b/10b encoding
   input wire link_init, // pulse: link initialization
   input wire ilas_done, // pulse: alignment sequence ended
   input wire sync_req_n, // receiver sync request, active low
   input wire [8*LANES-1:0] src_first_link, // transport data, first link
   input wire [8*LANES-1:0] src_second_link, // transport data, second link
   input wire src_valid, // transport data valid
   output reg src_ready_q, // transport data taken
   output wire [8*LANES-1:0] first_link_lanes, // octet per lane, first link
   output wire [8*LANES-1:0] second_link_lanes, // octet per lane, second link
   output wire [LANES-1:0] first_link_k, // control character flags
   output wire [LANES-1:0] second_link_k, // control character flags
   output wire frame_mf_start, // word opens a multiframe
   output wire lanes_valid, // lane word present
   input wire lanes_ready, // link layer takes the word
   output reg ilas_repeat_q, // link layer repeats alignment
   output reg cgs_restart_q // pulse: redo code group sync
);
   localparam W = 8 * LANES; // bits of one link
   localparam FW = 2 * W + 2 * LANES + 1; // buffer word width
   localparam PERIOD = K * ((M * S + 2 + K - 1) / K); // long period, frames
   localparam MFS = PERIOD / K; // multiframes per long period
   localparam MS = M * S; // samples per frame in long format

   // ****************************************************************
   // pattern functions
   // ****************************************************************
   // octets per lane in one frame
   function [3:0] frame_len;
      input [2:0] fmt;
      begin
         if (fmt == `JTP_FMT_N8) begin
            frame_len = `JTP_F_N8;
         end else if (fmt == `JTP_FMT_N12_F8) begin
            frame_len = `JTP_F_N12_F8;
         end else begin
            frame_len = `JTP_F_F2;
         end
      end
   endfunction

   // one nibble of the twelve-bit short pattern; p is the nibble position
   function [3:0] short_nib;
      input [2:0] fmt;
      input [7:0] lane;
      input [7:0] p;
      reg [7:0] smp;
      reg [7:0] dig;
      reg [7:0] run;
      begin
         smp = p / 8'd3;
         dig = p % 8'd3;
         run = lane * 8'd4 + p;
         if (fmt == `JTP_FMT_N12_F8) begin
            if (p == 8'd15) begin
               short_nib = `JTP_TAIL_NIBBLE; // tail nibble
            end else if (dig == 8'd0) begin
               short_nib = 4'hf - lane[3:0]; // lane tag, counting down
            end else if (dig == 8'd1) begin
               short_nib = lane[3:0];
            end else begin
               short_nib = smp[3:0] + 4'h1;
            end
         end else begin
            short_nib = run[3:0]; // nibble run 0..f continued lane to lane RQ2 RQ3
         end
      end
   endfunction

   // octet of the short pattern
   function [7:0] short_octet;
      input [2:0] fmt;
      input [7:0] lane;
      input [3:0] oct;
      input par;
      reg [7:0] p;
      begin
         p = {3'h0, oct, 1'b0};
         if (fmt == `JTP_FMT_N8) begin
            short_octet = (lane >= `JTP_LANES_N8) ? 8'h00 : par ? (8'hff - lane) : lane; // RQ1
         end else if ((fmt == `JTP_FMT_N12_F2_S8 && lane >= `JTP_LANES_S8) ||
                      (fmt == `JTP_FMT_N12_F2_S4 && lane >= `JTP_LANES_S4)) begin
            short_octet = 8'h00; // lane not used by this format
         end else begin
            short_octet = {short_nib(fmt, lane, p), short_nib(fmt, lane, p + 8'd1)}; // RQ1
         end
      end
   endfunction

   // octet of the long pattern; lane l holds converter l/S, sample l%S
   function [7:0] long_octet;
      input [7:0] lane;
      input [3:0] oct;
      input [15:0] idx;
      reg [31:0] data;
      reg [31:0] word;
      reg ctrl;
      begin
         if (idx == 16'd0) begin
            data = lane / S + 1; // converter index plus one, per link RQ6 RQ7
         end else if (idx == 16'd1) begin
            data = lane % S + 1; // sample position plus one RQ8
         end else begin
            data = 32'h1 << (N - 1); // mid value RQ9
         end
         ctrl = (CS > 0) && (idx < MS) && (idx == lane); // walking bit RQ10 RQ11
         word = (data << (16 - N)) | ({31'h0, ctrl} << (15 - N));
         if (lane >= MS) begin
            long_octet = 8'h00; // lane unused
         end else if (oct == 4'h0) begin
            long_octet = word[15:8];
         end else begin
            long_octet = word[7:0];
         end
      end
   endfunction

   // modified RPAT encoder input octet
   function [7:0] rpat_octet;
      input [3:0] i;
      begin
         case (i)
            4'h0: rpat_octet = `JTP_RPAT_0;
            4'h1: rpat_octet = `JTP_RPAT_1;
            4'h2: rpat_octet = `JTP_RPAT_2;
            4'h3: rpat_octet = `JTP_RPAT_3;
            4'h4: rpat_octet = `JTP_RPAT_4;
            4'h5: rpat_octet = `JTP_RPAT_5;
            4'h6: rpat_octet = `JTP_RPAT_6;
            4'h7: rpat_octet = `JTP_RPAT_7;
            4'h8: rpat_octet = `JTP_RPAT_8;
            4'h9: rpat_octet = `JTP_RPAT_9;
            4'ha: rpat_octet = `JTP_RPAT_10;
            default: rpat_octet = `JTP_RPAT_11;
         endcase
      end
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   reg [2:0] mode_q; // mode taken at link init
   reg [2:0] fmt_q; // format taken at link init
   reg running_q; // alignment done, pattern may flow
   reg sync_prev_q; // last sync request level
   reg [3:0] oct_q; // octet within frame
   reg [7:0] fr_q; // frame within multiframe
   reg [7:0] mfc_q; // multiframe within long period
   reg par_q; // frame parity for the two frame pattern
   reg [3:0] rp_q; // RPAT position
   wire fifo_ready; // buffer has room
   reg [FW-1:0] word_c; // word to push
   reg push_c; // push this cycle
   integer l; // lane loop index
   wire [31:0] idx = mfc_q * K + fr_q; // frame index within long period
   wire last_oct = (oct_q == frame_len(fmt_q) - 4'h1); // frame ends here
   wire last_fr = (fr_q == K - 1); // multiframe ends here
   wire gen_mode = (mode_q == `JTP_MODE_TRANSPORT) || (mode_q == `JTP_MODE_D215) ||
                   (mode_q == `JTP_MODE_K285) || (mode_q == `JTP_MODE_RPAT);
   wire gen_go = running_q && gen_mode && fifo_ready; // one generated word

   // ****************************************************************
   // mode latch and link control
   // ****************************************************************
   // selection is sampled only at link init so a frame never mixes sources;
   // 8b/10b-only modes fall back to normal data on other encodings
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= `JTP_RST_MODE;
         fmt_q <= `JTP_RST_FMT;
         running_q <= 1'b0;
         ilas_repeat_q <= 1'b0;
      end else if (link_init) begin
         if (test_mode_sel > `JTP_MODE_RPAT || (!enc_8b10b && (test_mode_sel == `JTP_MODE_K285 ||
             test_mode_sel == `JTP_MODE_RILA || test_mode_sel == `JTP_MODE_RPAT))) begin
            mode_q <= `JTP_MODE_OFF; // RQ15 RQ16
         end else begin
            mode_q <= test_mode_sel; // RQ19
         end
         fmt_q <= link_format_select;
         running_q <= 1'b0; // patterns restart with the link
         ilas_repeat_q <= enc_8b10b && (test_mode_sel == `JTP_MODE_RILA); // RQ16
      end else if (ilas_done) begin
         running_q <= 1'b1; // pattern follows the alignment sequence RQ13
      end
   end

   // repeated alignment: each new sync request asks for code group sync again
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sync_prev_q <= 1'b1;
         cgs_restart_q <= 1'b0;
      end else begin
         sync_prev_q <= sync_req_n;
         cgs_restart_q <= ilas_repeat_q && sync_prev_q && !sync_req_n; // RQ17
      end
   end

   // ****************************************************************
   // frame and multiframe counters
   // ****************************************************************
   // counters start on a multiframe boundary and the period spans whole
   // multiframes, so every long period opens a multiframe
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         oct_q <= 4'h0;
         fr_q <= 8'h00;
         mfc_q <= 8'h00;
         par_q <= 1'b0;
         rp_q <= 4'h0;
      end else if (!running_q) begin
         oct_q <= 4'h0; // RQ20
         fr_q <= 8'h00;
         mfc_q <= 8'h00;
         par_q <= 1'b0;
         rp_q <= 4'h0;
      end else if (gen_go) begin
         rp_q <= (rp_q == `JTP_RPAT_LEN - 4'h1) ? 4'h0 : rp_q + 4'h1; // RQ18
         if (last_oct) begin
            oct_q <= 4'h0;
            par_q <= !par_q;
            if (last_fr) begin
               fr_q <= 8'h00; // RQ20
               mfc_q <= (mfc_q == MFS - 1) ? 8'h00 : mfc_q + 8'h01; // repeat RQ5 RQ13
            end else begin
               fr_q <= fr_q + 8'h01;
            end
         end else begin
            oct_q <= oct_q + 4'h1;
         end
      end
   end

   // ****************************************************************
   // lane word builder
   // ****************************************************************
   // word layout: {mf start, second k, first k, second data, first data}
   always @* begin
      word_c = {FW{1'b0}};
      push_c = 1'b0;
      if (mode_q == `JTP_MODE_OFF) begin
         word_c[2*W-1:0] = {src_second_link, src_first_link}; // RQ19
         push_c = src_valid && src_ready_q;
      end else if (gen_go) begin
         push_c = 1'b1;
         word_c[FW-1] = (oct_q == 4'h0) && (fr_q == 8'h00);
         for (l = 0; l < LANES; l = l + 1) begin
            if (mode_q == `JTP_MODE_TRANSPORT && fmt_q == `JTP_FMT_N16) begin
               word_c[8*l +: 8] = long_octet(l[7:0], oct_q, idx[15:0]); // RQ4
               word_c[W + 8*l +: 8] = long_octet(l[7:0], oct_q, idx[15:0]); // RQ12
            end else if (mode_q == `JTP_MODE_TRANSPORT) begin
               word_c[8*l +: 8] = short_octet(fmt_q, l[7:0], oct_q, par_q); // RQ1
               word_c[W + 8*l +: 8] = short_octet(fmt_q, l[7:0], oct_q, par_q); // RQ3
            end else if (mode_q == `JTP_MODE_D215) begin
               word_c[8*l +: 8] = `JTP_D215; // RQ14
               word_c[W + 8*l +: 8] = `JTP_D215; // RQ14
            end else if (mode_q == `JTP_MODE_K285) begin
               word_c[8*l +: 8] = `JTP_K285; // RQ15
               word_c[W + 8*l +: 8] = `JTP_K285; // RQ15
               word_c[2*W + l] = 1'b1;
               word_c[2*W + LANES + l] = 1'b1;
            end else begin
               word_c[8*l +: 8] = rpat_octet(rp_q); // RQ18
               word_c[W + 8*l +: 8] = rpat_octet(rp_q); // RQ18
            end
         end
      end
   end

   // transport source ready lags buffer room by one cycle; buffer keeps a
   // spare slot for exactly this reason
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         src_ready_q <= 1'b0;
      end else begin
         src_ready_q <= (mode_q == `JTP_MODE_OFF) && !link_init && fifo_ready;
      end
   end

   // ****************************************************************
   // output buffer
   // ****************************************************************
   wire [FW-1:0] out_word; // registered buffer output
   jtp_fifo #(
      .WIDTH(FW),
      .DEPTH(DEPTH),
      .AW($clog2(DEPTH))
   ) u_fifo (
      .clock(clock),
      .arst_n(arst_n),
      .in_data(word_c),
      .in_valid(push_c),
      .in_ready(fifo_ready),
      .out_data(out_word),
      .out_valid(lanes_valid),
      .out_ready(lanes_ready)
   );
   assign first_link_lanes = out_word[W-1:0];
   assign second_link_lanes = out_word[2*W-1:W];
   assign first_link_k = out_word[2*W +: LANES];
   assign second_link_k = out_word[2*W+LANES +: LANES];
   assign frame_mf_start = out_word[FW-1];
endmodule // jtp_pattern_gen

// file: jtp_map.vh
/*
 * jtp_map.vh - constants of the link test pattern generator: test mode
 * codes, link format codes, fixed characters and the modified RPAT octets.
 * Assumes it is included by bare name from the design files of this block.
 */
`ifndef JTP_MAP_VH
`define JTP_MAP_VH

// ****************************************************************
// test mode selector codes
// ****************************************************************
`define JTP_MODE_OFF 3'h0
`define JTP_MODE_TRANSPORT 3'h1
`define JTP_MODE_D215 3'h2
`define JTP_MODE_K285 3'h3
`define JTP_MODE_RILA 3'h4
`define JTP_MODE_RPAT 3'h5

// ****************************************************************
// link format codes (sample width with control bits, octets, samples)
// ****************************************************************
`define JTP_FMT_N8 3'h0
`define JTP_FMT_N12_F8 3'h1
`define JTP_FMT_N12_F2_S8 3'h2
`define JTP_FMT_N12_F2_S4 3'h3
`define JTP_FMT_N16 3'h4

// ****************************************************************
// frame sizes in octets per lane
// ****************************************************************
`define JTP_F_N8 4'h1
`define JTP_F_N12_F8 4'h8
`define JTP_F_F2 4'h2

// ****************************************************************
// lanes used by the narrower formats, higher lanes idle at zero
// ****************************************************************
`define JTP_LANES_N8 4'h4
`define JTP_LANES_S8 4'h6
`define JTP_LANES_S4 4'h3

// ****************************************************************
// fixed characters and reset values
// ****************************************************************
`define JTP_D215 8'hb5
`define JTP_K285 8'hbc
`define JTP_TAIL_NIBBLE 4'h0
`define JTP_RPAT_LEN 4'hc
`define JTP_RST_MODE 3'h0
`define JTP_RST_FMT 3'h0

// ****************************************************************
// modified RPAT encoder input octets
// ****************************************************************
`define JTP_RPAT_0 8'hbe
`define JTP_RPAT_1 8'hd7
`define JTP_RPAT_2 8'h23
`define JTP_RPAT_3 8'h47
`define JTP_RPAT_4 8'h6b
`define JTP_RPAT_5 8'h8f
`define JTP_RPAT_6 8'hb3
`define JTP_RPAT_7 8'h14
`define JTP_RPAT_8 8'h5e
`define JTP_RPAT_9 8'hfb
`define JTP_RPAT_10 8'h35
`define JTP_RPAT_11 8'h59

`endif

// file: jtp_fifo.v
/*
 * jtp_fifo.v - synchronous FIFO with registered output stage.
 * Assumes a single clock; the writer stops pushing at most one cycle after in_ready falls.
 * in_ready drops one entry early so a source whose ready is one cycle late
 * still cannot overflow it.
 */
`timescale 1ns/1ps
module jtp_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire clock, // system clock
   input wire arst_n, // async reset, active low
   input wire [WIDTH-1:0] in_data, // write data
   input wire in_valid, // write strobe
   output reg in_ready, // room for a write
   output reg [WIDTH-1:0] out_data, // read data register
   output reg out_valid, // read data present
   input wire out_ready // reader takes the word
);
   reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage array
   reg [AW-1:0] wr_q; // write pointer
   reg [AW-1:0] rd_q; // read pointer
   reg [AW:0] cnt_q; // words held in the array
   wire push = in_valid; // writer honours in_ready at most one cycle late
   wire pop = (cnt_q != {(AW+1){1'b0}}) && (!out_valid || out_ready); // refill output
   wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop}; // next fill

   // ****************************************************************
   // pointers, fill and output stage
   // ****************************************************************
   // array itself has no reset, only control state does
   always @(posedge clock) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // control registers
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         in_ready <= 1'b0;
         out_valid <= 1'b0;
         out_data <= {WIDTH{1'b0}};
      end else begin
         cnt_q <= cnt_d;
         in_ready <= (cnt_d < DEPTH - 1); // one spare slot for late sources
         if (push) begin
            wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            out_data <= mem[rd_q];
            rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
            out_valid <= 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0; // word taken, nothing behind it
         end
      end
   end
endmodule // jtp_fifo

// file: jtp_link_rx_model.sv
/* jtp_link_rx_model.sv - far-side receiver stub: takes lane words with random
   stalls and raises a sync request on command.
   Assumes one clock; kick is a one-cycle command from the bench. */
`timescale 1ns/1ps
module jtp_link_rx_model (
   input wire clock, // system clock
   input wire arst_n, // async reset, active low
   input wire stall, // hold off every word
   input wire kick, // ask for one sync request
   output reg lanes_ready, // word taken
   output reg sync_req_n // sync request, active low
);
   integer seed = 7; // own fixed seed, separate from the bench
   integer hold = 0; // cycles left in the request
   // request length counted on the sampling edge
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) hold <= 0;
      else if (kick) hold <= 4;
      else if (hold > 0) hold <= hold - 1;
   end
   // outputs move on the falling edge, well away from sampling
   always @(negedge clock) begin
      lanes_ready <= !stall && ($random(seed) % 4 != 0); // prompt or slow
      sync_req_n <= (hold == 0);
   end
endmodule // jtp_link_rx_model

// file: jtp_pattern_gen_checker.sv
/* jtp_pattern_gen_checker.sv - port assertions of the test pattern source.
   Assumes it is bound to jtp_pattern_gen and sees only its ports. */
`timescale 1ns/1ps
module jtp_pattern_gen_checker #(
   parameter LANES = 8 // lanes per link
) (
   input wire clock, // system clock
   input wire arst_n, // async reset, active low
   input wire [2:0] test_mode_sel, // mode selector
   input wire enc_8b10b, // 8b/10b encoding
   input wire link_init, // link initialization pulse
   input wire ilas_done, // alignment end pulse
   input wire sync_req_n, // receiver sync request
   input wire src_ready_q, // source word taken
   input wire [8*LANES-1:0] first_link_lanes, // first link octets
   input wire [8*LANES-1:0] second_link_lanes, // second link octets
   input wire [LANES-1:0] first_link_k, // control flags
   input wire lanes_valid, // word present
   input wire lanes_ready, // word taken
   input wire ilas_repeat_q, // alignment repeat level
   input wire cgs_restart_q // sync restart pulse
);
   // 8b/10b-only modes fall back to normal data without that encoding
   wire [2:0] mode_d = (test_mode_sel > 3'h5 || (!enc_8b10b && test_mode_sel > 3'h2))
      ? 3'h0 : test_mode_sel;
   reg [2:0] mode_q; // mode in force since the last init
   reg wait_q; // between init and end of alignment
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= 3'h0;
         wait_q <= 1'b0;
      end else if (link_init) begin
         mode_q <= mode_d;
         wait_q <= 1'b1;
      end else if (ilas_done) begin
         wait_q <= 1'b0;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   a_links_same: assert property (lanes_valid && mode_q != 3'h0
      |-> first_link_lanes == second_link_lanes) else $error("links differ in test mode");
   a_d215_stream: assert property (lanes_valid && mode_q == 3'h2
      |-> first_link_lanes == {LANES{8'hb5}}) else $error("bad d21.5 word");
   a_k285_stream: assert property (lanes_valid && mode_q == 3'h3
      |-> first_link_lanes == {LANES{8'hbc}} && &first_link_k) else $error("bad k28.5 word");
   a_nothing_early: assert property (wait_q && mode_q != 3'h0 |-> !lanes_valid)
      else $error("pattern before alignment end");
   a_src_refused: assert property (mode_q != 3'h0 |-> !src_ready_q)
      else $error("source taken in test mode");
   a_ila_level: assert property (link_init
      |=> ilas_repeat_q == ($past(mode_d) == 3'h4)) else $error("repeat level wrong");
   a_cgs_after_req: assert property (ilas_repeat_q && $fell(sync_req_n)
      |-> ##[1:2] cgs_restart_q) else $error("no sync restart");
   a_cgs_single: assert property (cgs_restart_q |=> !cgs_restart_q)
      else $error("restart pulse too long");
   a_cgs_in_rila: assert property (cgs_restart_q |-> ilas_repeat_q)
      else $error("restart outside repeat mode");
   a_word_held: assert property (lanes_valid && !lanes_ready |=> lanes_valid
      && $stable(first_link_lanes) && $stable(second_link_lanes)) else $error("word dropped");
endmodule // jtp_pattern_gen_checker
bind jtp_pattern_gen jtp_pattern_gen_checker #(.LANES(LANES)) u_chk (.clock(clock),
   .arst_n(arst_n), .test_mode_sel(test_mode_sel), .enc_8b10b(enc_8b10b),
   .link_init(link_init), .ilas_done(ilas_done), .sync_req_n(sync_req_n),
   .src_ready_q(src_ready_q), .first_link_lanes(first_link_lanes),
   .second_link_lanes(second_link_lanes), .first_link_k(first_link_k),
   .lanes_valid(lanes_valid), .lanes_ready(lanes_ready), .ilas_repeat_q(ilas_repeat_q),
   .cgs_restart_q(cgs_restart_q));

// file: testbench.sv
/* testbench.sv - self-checking bench of the test pattern source.
   Assumes default parameters: 8 lanes, M=2, S=1, N=15, K=10, depth 32. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
   logic clock = 0, arst_n = 0, enc = 0, init = 0, ilas = 0, sv = 0, stall = 0, kick = 0;
   logic [2:0] sel = 0, fmt = 0;
   logic [63:0] sa = 0, sb = 0; // source words
   logic [127:0] ev; // expected word
   wire [63:0] la, lb;
   wire [7:0] ka, kb;
   wire ready, mfs, lv, lr, snr, rep, cgs;
   integer failures = 0, n_tests = 0, seed = 53399, cur = 0, w = 0, i, j, acc, ncgs;
   logic [127:0] q[$]; // accepted normal words
   logic [7:0] rpat [12] = '{8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f, 8'hb3, 8'h14,
      8'h5e, 8'hfb, 8'h35, 8'h59};
   int cs [13][3] = '{'{1,0,1}, '{1,1,1}, '{1,2,1}, '{1,3,1}, '{1,4,1}, '{2,0,0},
      '{3,0,1}, '{5,2,1}, '{4,0,1}, '{4,0,0}, '{3,0,0}, '{0,0,1}, '{6,0,1}};
   jtp_pattern_gen dut (.clock(clock), .arst_n(arst_n), .test_mode_sel(sel),
      .link_format_select(fmt), .enc_8b10b(enc), .link_init(init), .ilas_done(ilas),
      .sync_req_n(snr), .src_first_link(sa), .src_second_link(sb), .src_valid(sv),
      .src_ready_q(ready), .first_link_lanes(la), .second_link_lanes(lb),
      .first_link_k(ka), .second_link_k(kb), .frame_mf_start(mfs), .lanes_valid(lv),
      .lanes_ready(lr), .ilas_repeat_q(rep), .cgs_restart_q(cgs));
   jtp_link_rx_model rx (.clock(clock), .arst_n(arst_n), .stall(stall), .kick(kick),
      .lanes_ready(lr), .sync_req_n(snr));
   initial forever #5 clock = ~clock;
   // nibble k of a lane in the eight-octet twelve-bit frame, tail nibble 0
   function automatic [3:0] nib(input int l, input int k);
      int sm;
      sm = ((15 - l) << 8) | (l << 4) | (k / 3 + 1);
      nib = k > 14 ? 0 : (sm >> (4 * (2 - k % 3))) & 15;
   endfunction
   // transport pattern octet of lane l at word w since alignment end
   function automatic [7:0] exp_oct(input int l, input int w);
      int n, sm, fr;
      case (fmt)
         0: exp_oct = l > 3 ? 0 : (w % 2 ? 255 - l : l);
         1: exp_oct = {nib(l, 2 * (w % 8)), nib(l, 2 * (w % 8) + 1)};
         2, 3: begin
            n = (4 * l + 2 * (w % 2)) % 16;
            exp_oct = l < (fmt == 2 ? 6 : 3) ? (n << 4) | ((n + 1) % 16) : 0;
         end
         default: begin
            fr = (w / 2) % 10;
            sm = ((fr == 0 ? l + 1 : fr == 1 ? 1 : 16384) << 1) | (fr == l);
            exp_oct = l > 1 ? 0 : (w % 2 ? sm : sm >> 8);
         end
      endcase
   endfunction
   function automatic [63:0] exp_word(input int w);
      for (int l = 0; l < 8; l++)
         exp_word[8*l +: 8] = cur == 2 ? 8'hb5 : cur == 3 ? 8'hbc :
            cur == 5 ? rpat[w % 12] : exp_oct(l, w);
   endfunction
   // record accepted source words, check every word the far side takes
   always @(posedge clock) begin
      if (arst_n && sv && ready) q.push_back({sa, sb});
      if (arst_n && cgs) ncgs++;
      if (arst_n && lv && lr) begin
         ev = cur == 0 ? q.pop_front() : {2{exp_word(w)}};
         `CHK("lanes", ev, {la, lb})
         `CHK("k flags", (cur == 3 ? 16'hffff : 16'h0), {ka, kb})
         if (cur == 1)
            `CHK("mf start", (w % (fmt == 0 ? 10 : fmt == 1 ? 80 : 20) == 0), mfs)
         w++;
      end
   end
   // fill the buffer against a stalled far side, then drain it
   task automatic fill;
      stall = 1;
      acc = 0;
      for (i = 0; i < 40 && acc == i; i++) begin
         sa = {$random(seed), $random(seed)};
         sb = {$random(seed), $random(seed)};
         sv = 1;
         repeat (5) if (!ready) @(negedge clock);
         if (ready) acc++;
         @(negedge clock);
      end
      sv = 0;
      `CHK("refusal", 1'b1, acc < 40)
      stall = 0;
      while (q.size() > 0) @(negedge clock);
      repeat (4) @(negedge clock);
      `CHK("drained", 1'b0, lv)
   endtask
   task automatic run(input int s, input int f, input int e);
      arst_n = 0;
      sel = s;
      fmt = f;
      enc = e;
      repeat (2) @(negedge clock);
      arst_n = 1;
      cur = (s > 5 || (!e && s > 2)) ? 0 : s;
      w = 0;
      ncgs = 0;
      q = {};
      init = 1;
      @(negedge clock);
      init = 0;
      ilas = cur != 4;
      @(negedge clock);
      ilas = 0;
      if (cur == 0) fill;
      else if (cur == 4) begin
         repeat (3) begin
            kick = 1;
            @(negedge clock);
            kick = 0;
            repeat (12) @(negedge clock);
         end
         `CHK("repeat level", 1'b1, rep)
         `CHK("words", 0, w)
         `CHK("restarts", 3, ncgs)
      end else while (w < 100) @(negedge clock);
   endtask
   task end_sim;
      if (failures == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      for (j = 0; j < 13; j++) run(cs[j][0], cs[j][1], cs[j][2]);
      end_sim;
   end
   // about 1600 cycles expected; cut off far beyond that
   initial begin
      repeat (30000) @(posedge clock);
      failures++;
      end_sim;
   end
endmodule // testbench
